// ===== design/ehc_map.svh
// register offsets, field positions, reset values and protocol constants of the header comparator
`ifndef EHC_MAP_SVH
`define EHC_MAP_SVH
`define EHC_CTRL_OFS      8'h00
`define EHC_TPID_OFS      8'h04
`define EHC_MATCH_OFS     8'h08
`define EHC_RANGE_OFS     8'h0c
`define EHC_STATUS_OFS    8'h10
`define EHC_NXT_LSB       0
`define EHC_SIG_LSB       8
`define EHC_ETEN_BIT      16
`define EHC_RGEN_BIT      17
`define EHC_PBB_BIT       18
`define EHC_CTRL_RST      32'h0000_0000
`define EHC_TPID_RST      16'h8a88
`define EHC_MATCH_RST     32'h0000_0000
`define EHC_RANGE_RST     32'hffff_0000
`define EHC_CTAG_TPID     16'h8100
`define EHC_ITAG_TPID     16'h88e7
`define EHC_LEN_LIMIT     16'h0600
`define EHC_SAP_A         8'haa
`define EHC_SAP_B         8'hab
`define EHC_LLC_CTL       8'h03
`define EHC_OUI_ZERO      24'h00_0000
`define EHC_OUI_ALT       24'h00_00f8
`define EHC_LEN_ADDR      4'hc
`define EHC_LEN_TYPE      4'h2
`define EHC_LEN_TAG       4'h2
`define EHC_LEN_LLC       4'h3
`define EHC_LEN_SNAP      4'h5
`define EHC_LEN_ITAG      4'h4
`endif

// ===== design/ehc_pkg.sv
// types shared by the ethernet header comparator
package ehc_pkg;
  typedef enum logic [2:0] {
    EHC_ID_ETH1, EHC_ID_ETH2, EHC_ID_IP1, EHC_ID_IP2, EHC_ID_MPLS, EHC_ID_PTP
  } ehc_cmp_id_type;
  typedef enum {
    ST_IDLE, ST_ADDR, ST_TYPE, ST_TAG, ST_LLC, ST_SNAP, ST_ITAG, ST_DONE
  } ehc_state_type;
  typedef struct packed {
    logic       match;
    logic       type2;
    logic [7:0] offset;
    logic [2:0] nxt_cmp;
    logic [4:0] sig_ofs;
  } ehc_result_type;
endpackage : ehc_pkg

// ===== design/ehc_comparator.sv
// ethernet / llc / snap header comparator stage with apb configuration
`timescale 1ns/10ps
`include "ehc_map.svh"

module ehc_comparator #(
  parameter int INSTANCE = 0
) (
  input  wire logic                   clock_i,
  input  wire logic                   srst_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [7:0]             paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic      [31:0]            prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  input  wire logic                   valid_i,
  input  wire logic                   sof_i,
  input  wire logic                   eof_i,
  input  wire logic [7:0]             data_i,
  input  wire logic                   flow_hit_i,
  output logic                        result_valid_o,
  output ehc_pkg::ehc_result_type     result_o,
  output logic                        no_modify_indication_o
);

  // an engine holds exactly two of these, instance zero leading the chain
  if (INSTANCE < 0 || INSTANCE > 1) begin : g_bad_instance
    $error("INSTANCE must be 0 or 1");
  end

  logic [31:0]            ctrl_ff;
  logic [15:0]            tpid_ff;
  logic [31:0]            match_ff;
  logic [31:0]            range_ff;
  ehc_pkg::ehc_state_type state_ff;
  ehc_pkg::ehc_state_type nxt_state;
  ehc_pkg::ehc_state_type cur_st;
  logic [3:0]             fcnt_ff;
  logic [3:0]             cur_fcnt;
  logic [7:0]             pos_ff;
  logic [7:0]             cur_pos;
  logic [31:0]            acc_ff;
  logic [39:0]            field;
  logic [1:0]             tags_ff;
  logic [1:0]             nxt_tags;
  logic                   snap_ff;
  logic                   nxt_snap;
  logic [15:0]            etype_ff;
  logic [15:0]            nxt_etype;
  logic                   nxt_type2;
  logic                   in_byte;
  logic                   last;
  logic                   fin;
  logic                   fin_ok;
  logic                   pbb_on;
  logic                   is_tag;
  logic                   proto_ok;
  logic                   mm_ok;
  logic                   rg_ok;
  logic                   apb_acc;
  logic                   addr_ok;
  ehc_pkg::ehc_result_type res_ff;
  logic                   res_valid_ff;
  logic                   nomod_ff;

  // second instance has no backbone bit at all
  assign pbb_on = (INSTANCE == 0) && ctrl_ff[`EHC_PBB_BIT];

  // ---------------- apb slave, zero wait states
  assign apb_acc   = psel_i && penable_i;
  assign addr_ok   = paddr_i == `EHC_CTRL_OFS || paddr_i == `EHC_TPID_OFS ||
                     paddr_i == `EHC_MATCH_OFS || paddr_i == `EHC_RANGE_OFS ||
                     paddr_i == `EHC_STATUS_OFS;
  assign pready_o  = 1'b1;
  assign pslverr_o = apb_acc && !addr_ok;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ctrl_ff  <= `EHC_CTRL_RST;
      tpid_ff  <= `EHC_TPID_RST;
      match_ff <= `EHC_MATCH_RST;
      range_ff <= `EHC_RANGE_RST;
    end else if (apb_acc && pwrite_i) begin
      // one set for every flow of this comparator
      case (paddr_i)
        `EHC_CTRL_OFS:  ctrl_ff  <= pwdata_i & 32'h0007_1f07;
        `EHC_TPID_OFS:  tpid_ff  <= pwdata_i[15:0];
        `EHC_MATCH_OFS: match_ff <= pwdata_i;
        `EHC_RANGE_OFS: range_ff <= pwdata_i;
        default:        ;
      endcase
    end
  end

  always_comb begin
    prdata_o = 32'h0000_0000;
    if (apb_acc && !pwrite_i) begin
      case (paddr_i)
        `EHC_CTRL_OFS:   prdata_o = {ctrl_ff[31:19], pbb_on, ctrl_ff[17:0]};
        `EHC_TPID_OFS:   prdata_o = {16'h0000, tpid_ff};
        `EHC_MATCH_OFS:  prdata_o = match_ff;
        `EHC_RANGE_OFS:  prdata_o = range_ff;
        `EHC_STATUS_OFS: prdata_o = {etype_ff, 6'h00, res_ff.type2, res_ff.match,
                                     res_ff.offset};
        default:         prdata_o = 32'h0000_0000;
      endcase
    end
  end

  // ---------------- byte-wise header walk
  assign cur_st   = sof_i ? ehc_pkg::ST_ADDR : state_ff;
  assign cur_fcnt = sof_i ? 4'h0 : fcnt_ff;
  assign cur_pos  = sof_i ? 8'h00 : pos_ff;
  assign in_byte  = valid_i && (sof_i || (state_ff != ehc_pkg::ST_IDLE &&
                                          state_ff != ehc_pkg::ST_DONE));
  assign field    = {acc_ff, data_i};

  function automatic logic [3:0] flen(input ehc_pkg::ehc_state_type st);
    case (st)
      ehc_pkg::ST_ADDR: flen = `EHC_LEN_ADDR;
      ehc_pkg::ST_TYPE: flen = `EHC_LEN_TYPE;
      ehc_pkg::ST_TAG:  flen = `EHC_LEN_TAG;
      ehc_pkg::ST_LLC:  flen = `EHC_LEN_LLC;
      ehc_pkg::ST_SNAP: flen = `EHC_LEN_SNAP;
      ehc_pkg::ST_ITAG: flen = `EHC_LEN_ITAG;
      default:          flen = 4'h1;
    endcase
  endfunction : flen

  function automatic logic sap_ok(input logic [7:0] b);
    sap_ok = b == `EHC_SAP_A || b == `EHC_SAP_B;
  endfunction : sap_ok

  assign last = cur_fcnt == flen(cur_st) - 4'h1;
  // backbone mode knows only the global tpid for its b-tag
  assign is_tag = pbb_on ? (field[15:0] == tpid_ff)
                         : (field[15:0] == `EHC_CTAG_TPID || field[15:0] == tpid_ff);

  always_comb begin
    nxt_state = state_ff;
    nxt_tags  = tags_ff;
    nxt_snap  = snap_ff;
    nxt_etype = etype_ff;
    // type ii is known only at the final ethertype; never carried from the last frame
    nxt_type2 = 1'b0;
    fin       = 1'b0;
    fin_ok    = 1'b0;
    if (sof_i) begin
      nxt_tags  = 2'd0;
      nxt_snap  = 1'b0;
      nxt_type2 = 1'b0;
      nxt_state = ehc_pkg::ST_ADDR;
    end
    if (in_byte && last) begin
      case (cur_st)
        ehc_pkg::ST_ADDR: nxt_state = ehc_pkg::ST_TYPE;
        ehc_pkg::ST_TYPE: begin
          if (pbb_on && field[15:0] == `EHC_ITAG_TPID && nxt_tags <= 2'd1) begin
            nxt_etype = field[15:0];
            nxt_state = ehc_pkg::ST_ITAG;
          end else if (is_tag && nxt_tags < (pbb_on ? 2'd1 : 2'd2)) begin
            nxt_tags  = nxt_tags + 2'd1;
            nxt_state = ehc_pkg::ST_TAG;
          end else if (pbb_on) begin
            fin = 1'b1;
          end else if (field[15:0] < `EHC_LEN_LIMIT) begin
            nxt_state = ehc_pkg::ST_LLC;
          end else begin
            nxt_etype = field[15:0];
            nxt_type2 = 1'b1;
            fin       = 1'b1;
            fin_ok    = 1'b1;
          end
        end
        ehc_pkg::ST_TAG: begin
          if (snap_ff) begin
            fin    = 1'b1;
            fin_ok = 1'b1;
          end else begin
            nxt_state = ehc_pkg::ST_TYPE;
          end
        end
        ehc_pkg::ST_LLC: begin
          if (sap_ok(field[23:16]) && sap_ok(field[15:8]) && field[7:0] == `EHC_LLC_CTL)
            nxt_state = ehc_pkg::ST_SNAP;
          else
            fin = 1'b1;
        end
        ehc_pkg::ST_SNAP: begin
          if (field[39:16] == `EHC_OUI_ZERO || field[39:16] == `EHC_OUI_ALT) begin
            nxt_etype = field[15:0];
            nxt_snap  = 1'b1;
            if (field[15:0] == `EHC_CTAG_TPID || field[15:0] == tpid_ff) begin
              nxt_state = ehc_pkg::ST_TAG;
            end else begin
              fin    = 1'b1;
              fin_ok = 1'b1;
            end
          end else begin
            fin = 1'b1;
          end
        end
        ehc_pkg::ST_ITAG: begin
          fin    = 1'b1;
          fin_ok = 1'b1;
        end
        default: nxt_state = ehc_pkg::ST_IDLE;
      endcase
    end
    // frame ended inside the header
    if (in_byte && eof_i && !fin) begin
      fin = 1'b1;
    end
    if (fin) begin
      nxt_state = ehc_pkg::ST_DONE;
    end
  end

  // ---------------- next-protocol check on the last ethertype
  assign mm_ok = ((nxt_etype ^ match_ff[15:0]) & match_ff[31:16]) == 16'h0000;
  assign rg_ok = nxt_etype >= range_ff[15:0] && nxt_etype <= range_ff[31:16];
  // enables are ignored for llc/snap frames
  assign proto_ok = !nxt_type2 ||
                    ((!ctrl_ff[`EHC_ETEN_BIT] || mm_ok) &&
                     (!ctrl_ff[`EHC_RGEN_BIT] || rg_ok));

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_ff <= ehc_pkg::ST_IDLE;
      fcnt_ff  <= 4'h0;
      pos_ff   <= 8'h00;
      acc_ff   <= 32'h0000_0000;
      tags_ff  <= 2'd0;
      snap_ff  <= 1'b0;
      etype_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      tags_ff  <= nxt_tags;
      snap_ff  <= nxt_snap;
      etype_ff <= nxt_etype;
      if (in_byte) begin
        fcnt_ff <= last ? 4'h0 : cur_fcnt + 4'h1;
        acc_ff  <= last ? 32'h0000_0000 : field[31:0];
        pos_ff  <= cur_pos + 8'h01;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      res_ff       <= '0;
      res_valid_ff <= 1'b0;
      nomod_ff     <= 1'b0;
    end else begin
      res_valid_ff <= fin;
      // the flow comparator result arrives with the header byte that ends the walk
      nomod_ff     <= fin && !(fin_ok && proto_ok && flow_hit_i);
      if (fin) begin
        res_ff.match   <= fin_ok && proto_ok && flow_hit_i;
        res_ff.type2   <= nxt_type2;
        res_ff.offset  <= cur_pos + 8'h01;
        res_ff.nxt_cmp <= ctrl_ff[`EHC_NXT_LSB +: 3];
        res_ff.sig_ofs <= ctrl_ff[`EHC_SIG_LSB +: 5];
      end
    end
  end

  assign result_valid_o         = res_valid_ff;
  assign result_o               = res_ff;
  assign no_modify_indication_o = nomod_ff;

  // ---------------- assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  sequence llc_bad_s;
    in_byte && last && cur_st == ehc_pkg::ST_LLC &&
      !(sap_ok(field[23:16]) && sap_ok(field[15:8]) && field[7:0] == `EHC_LLC_CTL);
  endsequence
  sequence reject_s;
    result_valid_o && !result_o.match && no_modify_indication_o;
  endsequence

  nomod_pair_a: assert property (result_valid_o && !result_o.match |->
                                 no_modify_indication_o)
    else $error("non-match without no-modify");
  nomod_only_a: assert property (no_modify_indication_o |->
                                 result_valid_o && !result_o.match)
    else $error("no-modify without a rejected result");
  llc_reject_a: assert property (llc_bad_s |=> reject_s)
    else $error("bad llc header not rejected");
  pbb_second_a: assert property (INSTANCE != 0 |-> state_ff != ehc_pkg::ST_ITAG)
    else $error("backbone mode active in second instance");
  flow_gate_a: assert property (result_valid_o && result_o.match |->
                                $past(flow_hit_i))
    else $error("match without flow hit");
  offset_min_a: assert property (result_valid_o && result_o.match |->
                                 result_o.offset >= 8'd14)
    else $error("offset shorter than minimal header");
  nxt_code_a: assert property (fin |=> result_o.nxt_cmp == $past(ctrl_ff[2:0]))
    else $error("next comparator pointer not from config");
  etype_mask_a: assert property (result_valid_o && result_o.match && result_o.type2 &&
                                 ctrl_ff[`EHC_ETEN_BIT] |->
                                 ((etype_ff ^ match_ff[15:0]) & match_ff[31:16]) == 16'h0000)
    else $error("type ii ethertype accepted against match/mask");
  type2_off_a: assert property (result_valid_o && result_o.match && !result_o.type2 &&
                                !pbb_on |-> result_o.offset >= 8'd22)
    else $error("llc/snap result shorter than llc plus snap");
  // tag counter bounded by the longest legal form
  tag_limit_a: assert property (tags_ff != 2'd3)
    else $error("more than two vlan tags parsed");
  itag_tags_a: assert property (state_ff == ehc_pkg::ST_ITAG |-> tags_ff <= 2'd1)
    else $error("i-tag after more than one b-tag");
  one_shot_a: assert property (result_valid_o |=> !result_valid_o)
    else $error("result reported twice");

endmodule : ehc_comparator

// ===== tb/ehc_stream_src.sv
// header byte source standing in for the aligner that feeds the comparator
`timescale 1ns/10ps
module ehc_stream_src (
  input  wire logic       clock_i,
  output logic            valid_o,
  output logic            sof_o,
  output logic            eof_o,
  output logic [7:0]      data_o
);
  initial begin
    valid_o = 1'b0;
    sof_o   = 1'b0;
    eof_o   = 1'b0;
    data_o  = 8'h00;
  end

  // idle cycles carry the inverted last byte so stale data never looks valid
  task automatic send(input logic [7:0] q[$], input logic slow);
    for (int i = 0; i < q.size(); i++) begin
      if (slow && i[0]) begin
        @(posedge clock_i);
        valid_o <= 1'b0;
        sof_o   <= 1'b0;
        eof_o   <= 1'b0;
        data_o  <= ~data_o;
      end
      @(posedge clock_i);
      valid_o <= 1'b1;
      sof_o   <= (i == 0);
      eof_o   <= (i == q.size() - 1);
      data_o  <= q[i];
    end
    @(posedge clock_i);
    valid_o <= 1'b0;
    sof_o   <= 1'b0;
    eof_o   <= 1'b0;
    data_o  <= ~data_o;
  endtask : send
endmodule : ehc_stream_src

// ===== tb/tb.sv
// self-checking bench of the ethernet header comparator
`timescale 1ns/10ps
`include "ehc_map.svh"
module tb;
  logic                   clock = 1'b0;
  logic                   srst, psel, penable, pwrite, pready, pslverr;
  logic                   valid, sof, eof, flow_hit, rvalid, nomod;
  logic [7:0]             paddr, data;
  logic [31:0]            pwdata, prdata, prdata1, rd1;
  ehc_pkg::ehc_result_type res;
  ehc_pkg::ehc_result_type res1;
  logic [2:0]             nxt;
  logic [4:0]             sig;
  logic [7:0]             q[$];
  int                     err_count, num_checks, cyc, t;
  int                     seed = 54;

  always #25 clock = ~clock;

  ehc_comparator #(.INSTANCE(0)) ehc_comparator_inst (
    .clock_i(clock), .srst_i(srst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .valid_i(valid), .sof_i(sof), .eof_i(eof), .data_i(data),
    .flow_hit_i(flow_hit), .result_valid_o(rvalid), .result_o(res),
    .no_modify_indication_o(nomod));

  ehc_comparator #(.INSTANCE(1)) ehc_comparator_inst1 (
    .clock_i(clock), .srst_i(srst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata1), .pready_o(),
    .pslverr_o(), .valid_i(valid), .sof_i(sof), .eof_i(eof), .data_i(data),
    .flow_hit_i(flow_hit), .result_valid_o(), .result_o(res1),
    .no_modify_indication_o());

  ehc_stream_src ehc_stream_src_inst (
    .clock_i(clock), .valid_o(valid), .sof_o(sof), .eof_o(eof), .data_o(data));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    r = prdata;
    e = pslverr;
    rd1 = prdata1;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp, "read data");
    check(e, experr, "slave error");
  endtask : rdchk

  task automatic cfg(input logic [2:0] n, input logic [2:0] bits);
    nxt = n;
    sig = 5'($random(seed));
    wr(`EHC_CTRL_OFS, {13'h0, bits, 3'h0, sig, 5'h0, nxt});
  endtask : cfg

  function automatic void w16(input logic [15:0] v);
    q.push_back(v[15:8]);
    q.push_back(v[7:0]);
  endfunction : w16

  function automatic void addr();
    q.delete();
    repeat (12) q.push_back(8'($random(seed)));
  endfunction : addr

  function automatic void llc_snap(input logic [7:0] ds, input logic [7:0] ss,
                                   input logic [7:0] ct, input logic [23:0] oui,
                                   input logic [15:0] et);
    w16(16'h0020);
    q.push_back(ds); q.push_back(ss); q.push_back(ct);
    q.push_back(oui[23:16]); q.push_back(oui[15:8]); q.push_back(oui[7:0]);
    w16(et);
  endfunction : llc_snap

  // payload tail added so the result lands before the last byte
  task automatic frame(input logic fl, input logic m, input logic t2, input logic [7:0] ofs);
    ehc_pkg::ehc_result_type exp;
    int                      n;
    exp = '{m, t2, ofs, nxt, sig};
    w16(16'h5aa5);
    flow_hit <= fl;
    fork
      ehc_stream_src_inst.send(q, 1'($random(seed)));
      begin
        n = 0;
        do begin
          @(negedge clock);
          n++;
        end while (rvalid !== 1'b1 && n < 100);
        check(rvalid, 1'b1, "result pulse");
        if (m) check(res, exp, "result");
        check(res.match, m, "match");
        check(nomod, !m, "no modify");
        @(negedge clock);
        check(rvalid, 1'b0, "pulse");
      end
    join
  endtask : frame

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end

  initial begin
    srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; flow_hit = 1'b0;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    rdchk(`EHC_TPID_OFS, 32'h0000_8a88, 1'b0);
    rdchk(`EHC_RANGE_OFS, 32'hffff_0000, 1'b0);
    rdchk(`EHC_CTRL_OFS, 32'h0, 1'b0);
    rdchk(8'h40, 32'h0, 1'b1);
    for (int k = 0; k < 6; k++) begin
      cfg(3'(k), 3'b000);
      t = $unsigned($random(seed)) % 3;
      addr();
      for (int j = 0; j < t; j++) begin
        w16(j[0] ? 16'h8a88 : 16'h8100);
        w16(16'($random(seed)));
      end
      w16({8'h08, 8'($random(seed))});
      frame(k[0], k[0], 1'b1, 8'(14 + 4 * t));
    end
    wr(`EHC_TPID_OFS, 32'h0000_9100);
    addr(); w16(16'h9100); w16(16'h0123); w16(16'h0800);
    frame(1'b1, 1'b1, 1'b1, 18);
    addr(); w16(16'h8a88); w16(16'h0800);
    frame(1'b1, 1'b1, 1'b1, 14);
    wr(`EHC_TPID_OFS, 32'h0000_8a88);
    for (int k = 0; k < 4; k++) begin
      addr(); llc_snap(k[0] ? 8'hab : 8'haa, k[1] ? 8'hab : 8'haa, 8'h03, 24'h0, 16'h0800);
      frame(1'b1, 1'b1, 1'b0, 22);
    end
    addr(); llc_snap(8'haa, 8'haa, 8'h04, 24'h0, 16'h0800);
    frame(1'b1, 1'b0, 1'b0, 0);
    addr(); w16(16'h8100); w16(16'h0001); w16(16'h8a88); w16(16'h0002);
    llc_snap(8'haa, 8'haa, 8'h03, 24'h00_00f8, 16'h0800);
    frame(1'b1, 1'b1, 1'b0, 30);
    addr(); llc_snap(8'haa, 8'haa, 8'h03, 24'h00_0001, 16'h0800);
    frame(1'b1, 1'b0, 1'b0, 0);
    addr(); llc_snap(8'haa, 8'hab, 8'h03, 24'h0, 16'h8100); w16(16'h0064);
    frame(1'b1, 1'b1, 1'b0, 24);
    cfg(3'h5, 3'b001);
    wr(`EHC_MATCH_OFS, 32'hff00_8800);
    addr(); w16(16'h88aa);
    frame(1'b1, 1'b1, 1'b1, 14);
    addr(); w16(16'h89aa);
    frame(1'b1, 1'b0, 1'b1, 14);
    addr(); llc_snap(8'haa, 8'haa, 8'h03, 24'h0, 16'h0800);
    frame(1'b1, 1'b1, 1'b0, 22);
    cfg(3'h2, 3'b010);
    wr(`EHC_RANGE_OFS, 32'h0900_0800);
    addr(); w16(16'h0900);
    frame(1'b1, 1'b1, 1'b1, 14);
    addr(); w16(16'h0901);
    frame(1'b1, 1'b0, 1'b1, 14);
    cfg(3'h1, 3'b100);
    rdchk(`EHC_CTRL_OFS, {13'h0, 3'b100, 3'h0, sig, 5'h0, 3'h1}, 1'b0);
    check(rd1, {13'h0, 3'b000, 3'h0, sig, 5'h0, 3'h1}, "second ctrl");
    addr(); w16(16'h88e7); w16(16'h0000); w16(16'h0001);
    frame(1'b1, 1'b1, 1'b0, 18);
    check(res1.type2, 1'b1, "second type ii");
    check(res1.offset, 8'd14, "second offset");
    addr(); w16(16'h8a88); w16(16'h0005); w16(16'h88e7); w16(16'h0000); w16(16'h0001);
    frame(1'b1, 1'b1, 1'b0, 22);
    addr(); w16(16'h0800);
    frame(1'b1, 1'b0, 1'b0, 0);
    results();
  end
endmodule : tb
